// >>> hdl/crrss_consts.svh
// register offsets, opcodes, cycle counts and reset values of the executor
`ifndef CRRSS_CONSTS_SVH
`define CRRSS_CONSTS_SVH

// register map, byte addresses on the slave port
`define CRRSS_OFF_ISSUE     12'h000
`define CRRSS_OFF_ACC       12'h004
`define CRRSS_OFF_IDX       12'h008
`define CRRSS_OFF_SP        12'h00c
`define CRRSS_OFF_PC        12'h010
`define CRRSS_OFF_PS        12'h014
`define CRRSS_OFF_EXEC      12'h018
`define CRRSS_MEM_WIN_BIT   11

// field positions
`define CRRSS_ISSUE_OPC_LSB 0
`define CRRSS_ISSUE_OPR_LSB 8
`define CRRSS_EXEC_BUSY_BIT 0
`define CRRSS_EXEC_BAD_BIT  1

// opcodes
`define CRRSS_OPC_ROL_A     8'h2a
`define CRRSS_OPC_ROL_ZP    8'h26
`define CRRSS_OPC_ROR_A     8'h6a
`define CRRSS_OPC_ROR_ZP    8'h66
`define CRRSS_OPC_RRF_ZP    8'h82
`define CRRSS_OPC_RET_INT   8'h40
`define CRRSS_OPC_RET_SUB   8'h60
`define CRRSS_OPC_SBC_IMM   8'he9
`define CRRSS_OPC_SBC_ZP    8'he5
`define CRRSS_OPC_SEB_A_LO  5'h0b
`define CRRSS_OPC_SEB_ZP_LO 5'h0f
`define CRRSS_OPC_SET_C     8'h38
`define CRRSS_OPC_SET_D     8'hf8
`define CRRSS_OPC_SET_I     8'h78
`define CRRSS_OPC_SET_T     8'h32

// cycle counts
`define CRRSS_CYC_ROT_A     4'h2
`define CRRSS_CYC_ROT_ZP    4'h5
`define CRRSS_CYC_RRF       4'h8
`define CRRSS_CYC_RET       4'h6
`define CRRSS_CYC_SBC_IMM   4'h2
`define CRRSS_CYC_SBC_ZP    4'h3
`define CRRSS_CYC_SEB_A     4'h2
`define CRRSS_CYC_SEB_ZP    4'h5
`define CRRSS_CYC_FLAG      4'h2
`define CRRSS_CYC_T_EXTRA   4'h3
`define CRRSS_CYC_BAD       4'h1

// reset values
`define CRRSS_RST_ACC       8'h00
`define CRRSS_RST_IDX       8'h00
`define CRRSS_RST_SP        8'hff
`define CRRSS_RST_PC        16'h0000
`define CRRSS_RST_PS        8'h04

`endif

// >>> hdl/crrss_pkg.sv
// types shared by the executor files
package crrss_pkg;

   typedef struct packed {
      logic n;
      logic v;
      logic t;
      logic b;
      logic d;
      logic i;
      logic z;
      logic c;
   } crrss_ps_s;

   typedef enum logic [3:0] {
      op_rol_a, op_rol_zp, op_ror_a, op_ror_zp, op_rrf_zp, op_rti, op_rts,
      op_sbc_imm, op_sbc_zp, op_seb_a, op_seb_zp, op_sec, op_sed, op_sei,
      op_set, op_bad
   } crrss_op_e;

   typedef enum logic [3:0] {
      ex_idle, ex_rd, ex_op, ex_wr, ex_rdx, ex_opx, ex_pop, ex_popd, ex_hold
   } crrss_ex_e;

   typedef struct packed {
      logic       c;
      logic       v;
      logic [7:0] r;
   } crrss_alu_s;

   typedef struct packed {
      crrss_op_e  op;
      logic [3:0] cyc;
      logic [2:0] bit_sel;
   } crrss_dec_s;

endpackage

// >>> hdl/crrss_mem.sv
// zero page and stack page storage with a registered read port
`timescale 1ns/10ps
module crrss_mem #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   // clock
   input  wire logic          sys_clk,
   // access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output      logic [DW-1:0] rdata
);

   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   // read before write: the old byte is seen on a same-cycle read
   always_ff @(posedge sys_clk)
   begin
      if (we)
      begin
         mem_q[addr] <= wdata;
      end
      rdata <= mem_q[addr];
   end

endmodule

// >>> hdl/crrss_top.sv
// executor for rotate, return, subtract-with-borrow and set instructions
// Operation
// - rotate left moves bits up, bit7 to carry
// - rotate left: old carry to bit0; 2/5 cycles
// - rotate right moves bits down, bit0 to carry
// - rotate right: old carry to bit7; 2/5 cycles
// - nibble rotate swaps halves of zero-page byte
// - interrupt return pops status, low, high byte
// - subroutine return pops low then high byte
// - index mode clear: accumulator minus operand minus borrow
// - index mode set: result into byte at X
// - index mode set adds three subtract cycles
// - decimal mode leaves N V Z undefined; here V follows the binary result, N Z the bcd result
// - set-bit forces chosen bit of operand high
// - set-carry forces carry high
// - set-decimal forces decimal flag high
// - set-interrupt-disable forces interrupt flag high
// - set-index-mode forces index mode flag high
`timescale 1ns/10ps
`include "crrss_consts.svh"
module crrss_top #(
   parameter int MEM_AW = 9
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // avalon-mm slave
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   // core state
   output      logic        exec_busy,
   output      logic [7:0]  processor_status
);

   crrss_pkg::crrss_ex_e  st_q;
   crrss_pkg::crrss_dec_s dec_q;
   crrss_pkg::crrss_dec_s dec_d;
   crrss_pkg::crrss_ps_s  ps_q;
   crrss_pkg::crrss_alu_s alu_a;
   crrss_pkg::crrss_alu_s alu_x;
   crrss_pkg::crrss_alu_s rot;
   logic [3:0]            cnt_q;
   logic [1:0]            pops_q;
   logic [7:0]            a_q;
   logic [7:0]            x_q;
   logic [7:0]            sp_q;
   logic [7:0]            sp_inc;
   logic [15:0]           pc_q;
   logic [7:0]            opr_q;
   logic [7:0]            mval_q;
   logic [7:0]            wb_q;
   logic                  bad_q;
   logic                  busy_q;
   logic                  wait_q;
   logic                  mem_ph_q;
   logic [31:0]           rd_q;
   logic [31:0]           rd_val;
   logic                  idle;
   logic                  bus_wr;
   logic                  mem_win;
   logic                  start;
   logic                  mem_we;
   logic [MEM_AW-1:0]     mem_addr;
   logic [7:0]            mem_wdata;
   logic [7:0]            mem_rdata;

   function automatic crrss_pkg::crrss_dec_s dec_f(input logic [7:0] opc, input logic t);
      crrss_pkg::crrss_dec_s d;
      d.op      = crrss_pkg::op_bad;
      d.cyc     = `CRRSS_CYC_BAD;
      d.bit_sel = opc[7:5];
      if (opc[4:0] == `CRRSS_OPC_SEB_A_LO)
      begin
         d.op  = crrss_pkg::op_seb_a;
         d.cyc = `CRRSS_CYC_SEB_A;
      end
      else if (opc[4:0] == `CRRSS_OPC_SEB_ZP_LO)
      begin
         d.op  = crrss_pkg::op_seb_zp;
         d.cyc = `CRRSS_CYC_SEB_ZP;
      end
      else
      begin
         case (opc)
            `CRRSS_OPC_ROL_A:   begin d.op = crrss_pkg::op_rol_a;   d.cyc = `CRRSS_CYC_ROT_A;   end
            `CRRSS_OPC_ROL_ZP:  begin d.op = crrss_pkg::op_rol_zp;  d.cyc = `CRRSS_CYC_ROT_ZP;  end
            `CRRSS_OPC_ROR_A:   begin d.op = crrss_pkg::op_ror_a;   d.cyc = `CRRSS_CYC_ROT_A;   end
            `CRRSS_OPC_ROR_ZP:  begin d.op = crrss_pkg::op_ror_zp;  d.cyc = `CRRSS_CYC_ROT_ZP;  end
            `CRRSS_OPC_RRF_ZP:  begin d.op = crrss_pkg::op_rrf_zp;  d.cyc = `CRRSS_CYC_RRF;     end
            `CRRSS_OPC_RET_INT: begin d.op = crrss_pkg::op_rti;     d.cyc = `CRRSS_CYC_RET;     end
            `CRRSS_OPC_RET_SUB: begin d.op = crrss_pkg::op_rts;     d.cyc = `CRRSS_CYC_RET;     end
            `CRRSS_OPC_SBC_IMM: begin d.op = crrss_pkg::op_sbc_imm; d.cyc = `CRRSS_CYC_SBC_IMM; end
            `CRRSS_OPC_SBC_ZP:  begin d.op = crrss_pkg::op_sbc_zp;  d.cyc = `CRRSS_CYC_SBC_ZP;  end
            `CRRSS_OPC_SET_C:   begin d.op = crrss_pkg::op_sec;     d.cyc = `CRRSS_CYC_FLAG;    end
            `CRRSS_OPC_SET_D:   begin d.op = crrss_pkg::op_sed;     d.cyc = `CRRSS_CYC_FLAG;    end
            `CRRSS_OPC_SET_I:   begin d.op = crrss_pkg::op_sei;     d.cyc = `CRRSS_CYC_FLAG;    end
            `CRRSS_OPC_SET_T:   begin d.op = crrss_pkg::op_set;     d.cyc = `CRRSS_CYC_FLAG;    end
            default:            d.op = crrss_pkg::op_bad;
         endcase
      end
      if (t && (d.op == crrss_pkg::op_sbc_imm || d.op == crrss_pkg::op_sbc_zp))
      begin
         d.cyc = d.cyc + `CRRSS_CYC_T_EXTRA;
      end
      return d;
   endfunction

   // minuend - subtrahend - borrow; decimal result is bcd, V follows binary, N Z follow the bcd result
   function automatic crrss_pkg::crrss_alu_s sbc_f(input logic [7:0] a, input logic [7:0] m,
                                                  input logic c, input logic dec);
      crrss_pkg::crrss_alu_s res;
      logic [8:0] bin;
      logic [4:0] lo;
      logic [4:0] hi;
      bin   = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
      lo    = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
      hi    = {1'b0, a[7:4]} - {1'b0, m[7:4]} - {4'h0, lo[4]};
      res.r = bin[7:0];
      res.c = ~bin[8];
      res.v = (a[7] ^ m[7]) & (a[7] ^ bin[7]);
      if (dec)
      begin
         if (lo[4])
         begin
            lo = lo - 5'h06;
         end
         if (hi[4])
         begin
            hi = hi - 5'h06;
         end
         res.r = {hi[3:0], lo[3:0]};
         res.c = ~hi[4];
      end
      return res;
   endfunction

   function automatic crrss_pkg::crrss_alu_s rot_f(input crrss_pkg::crrss_op_e op,
                                                  input logic [7:0] v, input logic c,
                                                  input logic [2:0] b);
      crrss_pkg::crrss_alu_s res;
      res.c = c;
      res.v = 1'b0;
      res.r = v;
      case (op)
         crrss_pkg::op_rol_a, crrss_pkg::op_rol_zp:
         begin
            res.r = {v[6:0], c};
            res.c = v[7];
         end
         crrss_pkg::op_ror_a, crrss_pkg::op_ror_zp:
         begin
            res.r = {c, v[7:1]};
            res.c = v[0];
         end
         crrss_pkg::op_rrf_zp: res.r = {v[3:0], v[7:4]};
         crrss_pkg::op_seb_a, crrss_pkg::op_seb_zp: res.r = v | (8'h01 << b);
         default: res.r = v;
      endcase
      return res;
   endfunction

   assign idle    = (st_q == crrss_pkg::ex_idle);
   assign bus_wr  = ~wait_q & avs_write;
   assign mem_win = avs_address[`CRRSS_MEM_WIN_BIT];
   assign start   = bus_wr & idle & ~mem_win & avs_byteenable[0]
                    & (avs_address == `CRRSS_OFF_ISSUE);
   assign dec_d   = dec_f(avs_writedata[`CRRSS_ISSUE_OPC_LSB +: 8], ps_q.t);
   assign sp_inc  = sp_q + 8'h01;
   assign alu_a   = sbc_f(a_q, idle ? avs_writedata[`CRRSS_ISSUE_OPR_LSB +: 8] : mem_rdata,
                          ps_q.c, ps_q.d);
   assign alu_x   = sbc_f(mem_rdata, mval_q, ps_q.c, ps_q.d);
   assign rot     = rot_f(idle ? dec_d.op : dec_q.op, idle ? a_q : mem_rdata, ps_q.c,
                          idle ? dec_d.bit_sel : dec_q.bit_sel);

   assign avs_readdata     = rd_q;
   assign avs_waitrequest  = wait_q;
   assign exec_busy        = busy_q;
   assign processor_status = ps_q;

   // bus handshake: every access waits for an idle executor, memory reads take one more cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wait_q   <= 1'b1;
         mem_ph_q <= 1'b0;
         rd_q     <= 32'h0000_0000;
      end
      else if (!wait_q)
      begin
         wait_q <= 1'b1;
      end
      else if ((avs_read || avs_write) && idle)
      begin
         if (avs_read && mem_win && !mem_ph_q)
         begin
            mem_ph_q <= 1'b1;
         end
         else
         begin
            mem_ph_q <= 1'b0;
            wait_q   <= 1'b0;
            rd_q     <= avs_read ? rd_val : 32'h0000_0000;
         end
      end
   end

   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (mem_win)
      begin
         rd_val = {24'h000000, mem_rdata};
      end
      else
      begin
         case (avs_address)
            `CRRSS_OFF_ACC:  rd_val = {24'h000000, a_q};
            `CRRSS_OFF_IDX:  rd_val = {24'h000000, x_q};
            `CRRSS_OFF_SP:   rd_val = {24'h000000, sp_q};
            `CRRSS_OFF_PC:   rd_val = {16'h0000, pc_q};
            `CRRSS_OFF_PS:   rd_val = {24'h000000, ps_q};
            `CRRSS_OFF_EXEC: rd_val = {30'h00000000, bad_q, busy_q};
            default:         rd_val = 32'h0000_0000;
         endcase
      end
   end

   // sequencer: memory steps first, then hold until the documented count runs out
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_q   <= crrss_pkg::ex_idle;
         cnt_q  <= 4'h0;
         dec_q  <= '0;
         opr_q  <= 8'h00;
         mval_q <= 8'h00;
         wb_q   <= 8'h00;
         pops_q <= 2'b00;
         busy_q <= 1'b0;
         bad_q  <= 1'b0;
      end
      else
      begin
         if (!idle && cnt_q != 4'h0)
         begin
            cnt_q <= cnt_q - 4'h1;
         end
         case (st_q)
            crrss_pkg::ex_idle:
               if (start)
               begin
                  dec_q  <= dec_d;
                  cnt_q  <= dec_d.cyc;
                  opr_q  <= avs_writedata[`CRRSS_ISSUE_OPR_LSB +: 8];
                  mval_q <= avs_writedata[`CRRSS_ISSUE_OPR_LSB +: 8];
                  busy_q <= 1'b1;
                  bad_q  <= (dec_d.op == crrss_pkg::op_bad);
                  pops_q <= (dec_d.op == crrss_pkg::op_rti) ? 2'd2 : 2'd1;
                  case (dec_d.op)
                     crrss_pkg::op_rol_zp, crrss_pkg::op_ror_zp, crrss_pkg::op_rrf_zp,
                     crrss_pkg::op_seb_zp, crrss_pkg::op_sbc_zp: st_q <= crrss_pkg::ex_rd;
                     crrss_pkg::op_sbc_imm:
                        st_q <= ps_q.t ? crrss_pkg::ex_rdx : crrss_pkg::ex_hold;
                     crrss_pkg::op_rti, crrss_pkg::op_rts: st_q <= crrss_pkg::ex_pop;
                     default: st_q <= crrss_pkg::ex_hold;
                  endcase
               end
            crrss_pkg::ex_rd: st_q <= crrss_pkg::ex_op;
            crrss_pkg::ex_op:
               if (dec_q.op == crrss_pkg::op_sbc_zp)
               begin
                  mval_q <= mem_rdata;
                  st_q   <= ps_q.t ? crrss_pkg::ex_rdx : crrss_pkg::ex_hold;
               end
               else
               begin
                  wb_q <= rot.r;
                  st_q <= crrss_pkg::ex_wr;
               end
            crrss_pkg::ex_wr:   st_q <= crrss_pkg::ex_hold;
            crrss_pkg::ex_rdx:  st_q <= crrss_pkg::ex_opx;
            crrss_pkg::ex_opx:  st_q <= crrss_pkg::ex_hold;
            crrss_pkg::ex_pop:  st_q <= crrss_pkg::ex_popd;
            crrss_pkg::ex_popd:
            begin
               // three pops fill all six cycles, so the last pop may also end the run
               pops_q <= pops_q - 2'd1;
               st_q   <= (pops_q != 2'd0) ? crrss_pkg::ex_pop
                         : (cnt_q <= 4'h1) ? crrss_pkg::ex_idle : crrss_pkg::ex_hold;
               busy_q <= (pops_q != 2'd0) || (cnt_q > 4'h1);
            end
            crrss_pkg::ex_hold:
               if (cnt_q <= 4'h1)
               begin
                  st_q   <= crrss_pkg::ex_idle;
                  busy_q <= 1'b0;
               end
            default: st_q <= crrss_pkg::ex_idle;
         endcase
      end
   end

   // memory port: executor owns it while busy, the bus only when idle
   always_comb
   begin
      mem_we    = 1'b0;
      mem_wdata = wb_q;
      mem_addr  = avs_address[MEM_AW+1:2];
      case (st_q)
         crrss_pkg::ex_rd:  mem_addr = {1'b0, opr_q};
         crrss_pkg::ex_wr:
         begin
            mem_addr = {1'b0, opr_q};
            mem_we   = 1'b1;
         end
         crrss_pkg::ex_rdx: mem_addr = {1'b0, x_q};
         crrss_pkg::ex_opx:
         begin
            mem_addr  = {1'b0, x_q};
            mem_we    = 1'b1;
            mem_wdata = alu_x.r;
         end
         crrss_pkg::ex_pop: mem_addr = {1'b1, sp_inc};
         crrss_pkg::ex_idle:
            if (bus_wr && mem_win && avs_byteenable[0])
            begin
               mem_we    = 1'b1;
               mem_wdata = avs_writedata[7:0];
            end
         default: mem_we = 1'b0;
      endcase
   end

   crrss_mem #(
      .AW (MEM_AW),
      .DW (8)
   ) u_mem (
      .sys_clk (sys_clk),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata   (mem_rdata)
   );

   // accumulator
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         a_q <= `CRRSS_RST_ACC;
      end
      else if (idle && bus_wr && !mem_win && avs_address == `CRRSS_OFF_ACC && avs_byteenable[0])
      begin
         a_q <= avs_writedata[7:0];
      end
      else if (start)
      begin
         case (dec_d.op)
            crrss_pkg::op_rol_a, crrss_pkg::op_ror_a, crrss_pkg::op_seb_a: a_q <= rot.r;
            crrss_pkg::op_sbc_imm: if (!ps_q.t) a_q <= alu_a.r;
            default: a_q <= a_q;
         endcase
      end
      else if (st_q == crrss_pkg::ex_op && dec_q.op == crrss_pkg::op_sbc_zp && !ps_q.t)
      begin
         a_q <= alu_a.r;
      end
   end

   // processor status flags
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         ps_q <= `CRRSS_RST_PS;
      end
      else if (idle && bus_wr && !mem_win && avs_address == `CRRSS_OFF_PS && avs_byteenable[0])
      begin
         ps_q <= avs_writedata[7:0];
      end
      else if (start)
      begin
         case (dec_d.op)
            crrss_pkg::op_sec: ps_q.c <= 1'b1;
            crrss_pkg::op_sed: ps_q.d <= 1'b1;
            crrss_pkg::op_sei: ps_q.i <= 1'b1;
            crrss_pkg::op_set: ps_q.t <= 1'b1;
            crrss_pkg::op_rol_a, crrss_pkg::op_ror_a:
            begin
               ps_q.c <= rot.c;
               ps_q.n <= rot.r[7];
               ps_q.z <= (rot.r == 8'h00);
            end
            crrss_pkg::op_sbc_imm:
               if (!ps_q.t)
               begin
                  // in decimal mode V comes from the binary path, N Z from the bcd result
                  ps_q.c <= alu_a.c;
                  ps_q.v <= alu_a.v;
                  ps_q.n <= alu_a.r[7];
                  ps_q.z <= (alu_a.r == 8'h00);
               end
            default: ps_q <= ps_q;
         endcase
      end
      else if (st_q == crrss_pkg::ex_op && dec_q.op == crrss_pkg::op_sbc_zp && !ps_q.t)
      begin
         ps_q.c <= alu_a.c;
         ps_q.v <= alu_a.v;
         ps_q.n <= alu_a.r[7];
         ps_q.z <= (alu_a.r == 8'h00);
      end
      else if (st_q == crrss_pkg::ex_op &&
               (dec_q.op == crrss_pkg::op_rol_zp || dec_q.op == crrss_pkg::op_ror_zp))
      begin
         ps_q.c <= rot.c;
         ps_q.n <= rot.r[7];
         ps_q.z <= (rot.r == 8'h00);
      end
      else if (st_q == crrss_pkg::ex_opx)
      begin
         ps_q.c <= alu_x.c;
         ps_q.v <= alu_x.v;
         ps_q.n <= alu_x.r[7];
         ps_q.z <= (alu_x.r == 8'h00);
      end
      else if (st_q == crrss_pkg::ex_popd && pops_q == 2'd2)
      begin
         ps_q <= mem_rdata;
      end
   end

   // index, stack pointer and program counter
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         x_q  <= `CRRSS_RST_IDX;
         sp_q <= `CRRSS_RST_SP;
         pc_q <= `CRRSS_RST_PC;
      end
      else if (idle && bus_wr && !mem_win)
      begin
         if (avs_address == `CRRSS_OFF_IDX && avs_byteenable[0])
            x_q <= avs_writedata[7:0];
         if (avs_address == `CRRSS_OFF_SP && avs_byteenable[0])
            sp_q <= avs_writedata[7:0];
         if (avs_address == `CRRSS_OFF_PC && avs_byteenable[0])
            pc_q[7:0] <= avs_writedata[7:0];
         if (avs_address == `CRRSS_OFF_PC && avs_byteenable[1])
            pc_q[15:8] <= avs_writedata[15:8];
      end
      else if (st_q == crrss_pkg::ex_pop)
      begin
         sp_q <= sp_inc;
      end
      else if (st_q == crrss_pkg::ex_popd && pops_q == 2'd1)
      begin
         pc_q[7:0] <= mem_rdata;
      end
      else if (st_q == crrss_pkg::ex_popd && pops_q == 2'd0)
      begin
         pc_q[15:8] <= mem_rdata;
      end
   end

endmodule

// >>> verification/crrss_properties.sv
// port assertions for the instruction executor
`timescale 1ns/10ps
module crrss_properties (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // register bus
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // core state
   input wire logic        exec_busy,
   input wire logic [7:0]  processor_status
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic       iss;
   logic [7:0] opc;
   assign iss = avs_write && !avs_waitrequest && avs_address == 12'h000;
   assign opc = avs_writedata[7:0];
   a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice");
   a_ack_needs_req: assert property (!avs_waitrequest |-> avs_read || avs_write)
      else $error("ack without request");
   a_no_ack_busy: assert property (exec_busy |-> avs_waitrequest)
      else $error("ack while busy");
   a_carry_set: assert property (iss && opc == 8'h38 |=> processor_status[0]
      ##0 exec_busy[*2] ##1 !exec_busy) else $error("carry op wrong");
   a_dec_set: assert property (iss && opc == 8'hf8 |=> processor_status[3])
      else $error("decimal flag not set");
   a_irq_set: assert property (iss && opc == 8'h78 |=> processor_status[2])
      else $error("interrupt mask not set");
   a_idx_set: assert property (iss && opc == 8'h32 |=> processor_status[5])
      else $error("index mode not set");
   a_rotl_len: assert property (iss && opc == 8'h26 |=> exec_busy[*5] ##1 !exec_busy)
      else $error("rotate length wrong");
   a_nib_len: assert property (iss && opc == 8'h82 |=> exec_busy[*8] ##1 !exec_busy)
      else $error("nibble rotate length wrong");
   a_ret_len: assert property (iss && (opc == 8'h40 || opc == 8'h60)
      |=> exec_busy[*6] ##1 !exec_busy) else $error("return length wrong");
   a_sub_len: assert property (iss && opc == 8'he5 && processor_status[5]
      |=> exec_busy[*6] ##1 !exec_busy) else $error("index subtract length wrong");
   c_ret: cover property (iss && opc == 8'h40);
   c_sub_idx: cover property (iss && opc == 8'he5 && processor_status[5]);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind crrss_top crrss_properties i_crrss_properties (.sys_clk, .rstn, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .exec_busy,
   .processor_status);

// >>> verification/crrss_bus_master.sv
// avalon-mm master standing in for software on the register bus
`timescale 1ns/10ps
module crrss_bus_master (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // command from the bench
   input  wire logic        go,
   input  wire logic        wr,
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   output      logic        done,
   output      logic [31:0] rdata,
   // avalon-mm master
   output      logic [11:0] avs_address,
   output      logic        avs_read,
   output      logic        avs_write,
   output      logic [31:0] avs_writedata,
   output      logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   assign avs_byteenable = 4'hf;
   initial
   begin
      {done, avs_read, avs_write} = 3'h0;
      avs_address = 12'h000;
      avs_writedata = 32'h0;
      rdata = 32'h0;
   end
   // released address and data lines are inverted so a stale value never looks valid
   always @(posedge sys_clk)
   begin
      done <= 1'b0;
      if (!rstn)
      begin
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
      else if (go && !avs_read && !avs_write)
      begin
         avs_read <= !wr;
         avs_write <= wr;
         avs_address <= addr;
         avs_writedata <= wdata;
      end
      else if ((avs_read || avs_write) && !avs_waitrequest)
      begin
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         avs_address <= ~avs_address;
         avs_writedata <= ~avs_writedata;
         rdata <= avs_readdata;
         done <= 1'b1;
      end
   end
endmodule

// >>> verification/test_cpu_rotate_return_subtract_set_ops.sv
// self-checking bench for the instruction executor
`timescale 1ns/10ps
module test_cpu_rotate_return_subtract_set_ops;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        go = 1'b0;
   logic        wr = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        done, avs_read, avs_write, avs_waitrequest, exec_busy;
   logic [11:0] avs_address;
   logic [31:0] rdata, rv, avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [7:0]  processor_status;
   int          bad_count = 0;
   int          check_count = 0;
   always #5 sys_clk = ~sys_clk;
   crrss_top i_crrss_top (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .exec_busy, .processor_status);
   crrss_bus_master i_crrss_bus_master (.sys_clk, .rstn, .go, .wr, .addr, .wdata, .done, .rdata,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest);
   task ck(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // the bus stalls while busy, so each access also waits out the instruction
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 40) ck(32'h1, 32'h0);
      rv = rdata;
   endtask
   task w(input logic [11:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task rc(input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      ck(rv, e);
   endtask
   task iss(input logic [7:0] o, input logic [7:0] p);
      w(12'h000, {16'h0, p, o});
   endtask
   function automatic logic [11:0] m(input logic [8:0] i);
      return {1'b1, i, 2'b00};
   endfunction
   task t_base;
      rc(12'h014, 32'h4);
      rc(12'h00c, 32'hff);
      rc(12'h01c, 32'h0);
      iss(8'h02, 8'h00);
      rc(12'h018, 32'h2);
   endtask
   task t_rot;
      w(12'h004, 32'h81);
      w(12'h014, 32'h0);
      iss(8'h2a, 8'h00);
      rc(12'h004, 32'h02);
      ck({31'h0, processor_status[0]}, 32'h1);
      w(m(9'h10), 32'h40);
      iss(8'h26, 8'h10);
      rc(m(9'h10), 32'h81);
      w(12'h004, 32'h01);
      iss(8'h6a, 8'h00);
      rc(12'h004, 32'h00);
      w(m(9'h20), 32'h02);
      iss(8'h66, 8'h20);
      rc(m(9'h20), 32'h81);
      w(m(9'h30), 32'ha5);
      iss(8'h82, 8'h30);
      rc(m(9'h30), 32'h5a);
   endtask
   task t_ret;
      w(12'h00c, 32'hfc);
      w(m(9'h1fd), 32'hc1);
      w(m(9'h1fe), 32'h34);
      w(m(9'h1ff), 32'h12);
      iss(8'h40, 8'h00);
      rc(12'h010, 32'h1234);
      rc(12'h014, 32'hc1);
      rc(12'h00c, 32'hff);
      w(12'h00c, 32'hfc);
      w(m(9'h1fd), 32'h78);
      w(m(9'h1fe), 32'h56);
      iss(8'h60, 8'h00);
      rc(12'h010, 32'h5678);
      rc(12'h00c, 32'hfe);
   endtask
   task t_sub;
      w(12'h014, 32'h01);
      w(12'h004, 32'h50);
      iss(8'he9, 8'h20);
      rc(12'h004, 32'h30);
      ck({31'h0, processor_status[0]}, 32'h1);
      w(12'h014, 32'h00);
      w(12'h004, 32'h10);
      iss(8'he9, 8'h20);
      rc(12'h004, 32'hef);
      ck({31'h0, processor_status[0]}, 32'h0);
      w(12'h014, 32'h21);
      w(12'h008, 32'h40);
      w(m(9'h40), 32'h50);
      w(m(9'h44), 32'h10);
      iss(8'he5, 8'h44);
      rc(m(9'h40), 32'h40);
      rc(12'h004, 32'hef);
      w(12'h014, 32'h09);
      w(12'h004, 32'h42);
      iss(8'he9, 8'h15);
      rc(12'h004, 32'h27);
      ck({31'h0, processor_status[0]}, 32'h1);
   endtask
   task t_set;
      for (int b = 0; b < 8; b++)
      begin
         w(12'h004, 32'h0);
         iss({b[2:0], 5'h0b}, 8'h00);
         rc(12'h004, 32'h1 << b);
      end
      w(m(9'h50), 32'h0);
      iss(8'hef, 8'h50);
      rc(m(9'h50), 32'h80);
      w(12'h014, 32'h0);
      iss(8'h38, 8'h00);
      iss(8'hf8, 8'h00);
      iss(8'h78, 8'h00);
      iss(8'h32, 8'h00);
      rc(12'h014, 32'h2d);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      t_base;
      t_rot;
      t_ret;
      t_sub;
      t_set;
      wrap_up;
   end
   initial
   begin
      #60000;
      bad_count++;
      wrap_up;
   end
endmodule
